/* ddc_defs.svh */
// Summary of operation
// - ODT low, tAOFD before EMRS, through tMOD
// - activate encoding; activate before any column access
// - precharge before reactivate; honour tRC and tRRD
// - read encoding with bank and column
// - write encoding with bank and column
// - ODT off, then refresh with CKE low
// - clock may stop only inside self-refresh
// - exit: only NOP, CKE high, ODT off
// - one auto refresh before next self-refresh
// - auto refresh encoding at average interval
// - wait tRFC after refresh before activate/refresh
// - at most eight refreshes postponed
// - never interrupt a burst; a refresh can follow a column command with auto-precharge on the next clock
// - column commands at least two clocks apart
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
`define DDC_CTRL_OFF 12'h000
`define DDC_CMD_OFF 12'h004
`define DDC_STAT_OFF 12'h008
`define DDC_CTRL_SR_BIT 0
`define DDC_CTRL_REF_BIT 1
`define DDC_CTRL_ODT_BIT 2
`define DDC_CTRL_RST 32'h0000_0000
`define DDC_CMD_AP_BIT 3
`define DDC_CMD_BA_LSB 4
`define DDC_CMD_ADDR_LSB 8
`define DDC_STAT_ERR_BIT 16
`define DDC_T_CK_NS 25
`define DDC_T_RC_NS 55
`define DDC_T_RRD_NS 10
`define DDC_T_RP_NS 15
`define DDC_T_RAS_NS 40
`define DDC_T_WR_NS 15
`define DDC_T_RFC_NS 105
`define DDC_T_XSNR_NS 115
`define DDC_T_AOFD_NS 63
`define DDC_T_MODMAX_NS 12
`define DDC_T_REFI_NS 7800
`define DDC_CYC(ns) (((ns) + `DDC_T_CK_NS - 1) / `DDC_T_CK_NS)
`define DDC_MAX_OWED 4'h8
`endif

/* ddc_pkg.sv */
package ddc_pkg;
  typedef enum logic [2:0] {
    DDC_OP_ACT = 3'h0,
    DDC_OP_RD = 3'h1,
    DDC_OP_WR = 3'h2,
    DDC_OP_PREA = 3'h3,
    DDC_OP_EMRS = 3'h4
  } ddc_op_t;
  typedef enum logic [5:0] {
    DDC_IDLE = 6'h01,
    DDC_ODT_OFF = 6'h02,
    DDC_MOD_WAIT = 6'h04,
    DDC_SREF = 6'h08,
    DDC_SR_EXIT = 6'h10
  } ddc_state_t;
endpackage

/* ddc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defs.svh"
module ddc_ctrl
  import ddc_pkg::*;
#(
  parameter int AL = 0,
  parameter int CL = 4,
  parameter int BL = 4
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ddr_cke,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [1:0] ddr_ba,
  output logic [12:0] ddr_a,
  output logic ddr_odt
);
  localparam logic [8:0] C_RC = 9'(`DDC_CYC(`DDC_T_RC_NS));
  localparam logic [8:0] C_RRD = 9'(`DDC_CYC(`DDC_T_RRD_NS));
  localparam logic [8:0] C_RP = 9'(`DDC_CYC(`DDC_T_RP_NS));
  localparam logic [8:0] C_RAS = 9'(`DDC_CYC(`DDC_T_RAS_NS));
  localparam logic [8:0] C_RFC = 9'(`DDC_CYC(`DDC_T_RFC_NS));
  localparam logic [8:0] C_XSNR = 9'(`DDC_CYC(`DDC_T_XSNR_NS));
  localparam logic [8:0] C_AOFD = 9'(`DDC_CYC(`DDC_T_AOFD_NS));
  localparam logic [8:0] C_MOD = 9'(`DDC_CYC(`DDC_T_MODMAX_NS));
  localparam logic [8:0] C_REFI = 9'(`DDC_CYC(`DDC_T_REFI_NS));
  localparam logic [8:0] C_WR = 9'(`DDC_CYC(`DDC_T_WR_NS));
  localparam logic [8:0] C_HALF = 9'(BL / 2);
  localparam logic [8:0] C_RD_PRE = 9'(AL) + C_HALF;
  localparam logic [8:0] C_WR_PRE = 9'(AL + CL - 1) + C_HALF + C_WR;

  function automatic logic [8:0] max9(input logic [8:0] a, input logic [8:0] b);
    max9 = (a > b) ? a : b;
  endfunction

  function automatic logic [8:0] dec9(input logic [8:0] a);
    dec9 = (a != 9'h000) ? a - 9'h001 : 9'h000;
  endfunction

  ddc_state_t state_r;
  logic [31:0] ctrl_r;
  logic cmd_valid_r;
  ddc_op_t cmd_op_r;
  logic cmd_ap_r;
  logic [1:0] cmd_ba_r;
  logic [12:0] cmd_addr_r;
  logic err_r;
  logic [3:0] bank_open_r;
  logic [8:0] bk_cnt_r [4];
  logic [8:0] rrd_cnt_r;
  logic [8:0] all_cnt_r;
  logic [8:0] col_cnt_r;
  logic [8:0] pre_cnt_r;
  logic [8:0] wait_cnt_r;
  logic [8:0] ref_tmr_r;
  logic [3:0] owed_r;
  logic need_ref_r;
  logic tgt_sr_r;
  logic wr_acc;
  logic iss_act, iss_col, iss_prea, iss_ref, iss_odt_off, refuse;
  logic all_closed, ref_force, ref_tick;

  assign wr_acc = psel & penable & pready & pwrite;
  assign all_closed = (bank_open_r == 4'h0);
  assign ref_force = (owed_r == `DDC_MAX_OWED);
  assign ref_tick = ctrl_r[`DDC_CTRL_REF_BIT] && (state_r != DDC_SREF) && (ref_tmr_r == 9'h000);

  // apb slave: pready rises in the access phase, so every transfer takes exactly two cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        if (paddr == `DDC_CTRL_OFF)
          prdata <= ctrl_r;
        else if (paddr == `DDC_CMD_OFF)
          prdata <= {19'h00000, cmd_addr_r} & 32'h0000_0000;
        else if (paddr == `DDC_STAT_OFF)
          prdata <= {15'h0000, err_r, 4'h0, owed_r, bank_open_r, 1'b0, need_ref_r, state_r == DDC_SREF, cmd_valid_r};
        else
        begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `DDC_CTRL_RST;
    else if (wr_acc && paddr == `DDC_CTRL_OFF)
      ctrl_r <= pwdata & 32'h0000_0007;
  end

  // a command written while one is pending is dropped and flagged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_valid_r <= 1'b0;
      cmd_op_r <= DDC_OP_ACT;
      cmd_ap_r <= 1'b0;
      cmd_ba_r <= 2'h0;
      cmd_addr_r <= 13'h0000;
    end
    else if (wr_acc && paddr == `DDC_CMD_OFF && !cmd_valid_r)
    begin
      cmd_valid_r <= 1'b1;
      cmd_op_r <= ddc_op_t'(pwdata[2:0]);
      cmd_ap_r <= pwdata[`DDC_CMD_AP_BIT];
      cmd_ba_r <= pwdata[`DDC_CMD_BA_LSB +: 2];
      cmd_addr_r <= pwdata[`DDC_CMD_ADDR_LSB +: 13];
    end
    else if (iss_act || iss_col || (iss_prea && !ref_force) || refuse)
      cmd_valid_r <= 1'b0;
    // emrs stays pending until it reaches the pins, so a new write cannot overwrite its fields
    else if (state_r == DDC_ODT_OFF && wait_cnt_r <= 9'h001 && !tgt_sr_r)
      cmd_valid_r <= 1'b0;
  end

  // set wins over the software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_r <= 1'b0;
    else if (refuse || (wr_acc && paddr == `DDC_CMD_OFF && cmd_valid_r))
      err_r <= 1'b1;
    else if (wr_acc && paddr == `DDC_STAT_OFF && pwdata[`DDC_STAT_ERR_BIT])
      err_r <= 1'b0;
  end

  // issue decision; refresh outranks user commands once eight are owed
  always_comb
  begin
    iss_act = 1'b0;
    iss_col = 1'b0;
    iss_prea = 1'b0;
    iss_ref = 1'b0;
    iss_odt_off = 1'b0;
    refuse = 1'b0;
    if (state_r == DDC_IDLE)
    begin
      // the extra refresh after self-refresh exit must not wait for the interval timer
      if ((owed_r != 4'h0 || need_ref_r) && all_closed && all_cnt_r == 9'h000 && (ref_force || !cmd_valid_r))
        iss_ref = 1'b1;
      else if (ref_force)
        iss_prea = !all_closed && pre_cnt_r == 9'h000;
      else if (cmd_valid_r)
      begin
        case (cmd_op_r)
          DDC_OP_ACT:
            if (bank_open_r[cmd_ba_r])
              refuse = 1'b1;
            else
              iss_act = bk_cnt_r[cmd_ba_r] == 9'h000 && rrd_cnt_r == 9'h000 && all_cnt_r == 9'h000;
          DDC_OP_RD, DDC_OP_WR:
            if (!bank_open_r[cmd_ba_r])
              refuse = 1'b1;
            else
              iss_col = col_cnt_r == 9'h000;
          DDC_OP_PREA:
            iss_prea = pre_cnt_r == 9'h000;
          DDC_OP_EMRS:
            if (!all_closed)
              refuse = 1'b1;
            else
              iss_odt_off = all_cnt_r == 9'h000;
          default:
            refuse = 1'b1;
        endcase
      end
      else if (ctrl_r[`DDC_CTRL_SR_BIT] && !need_ref_r && all_closed && all_cnt_r == 9'h000)
        iss_odt_off = 1'b1;
    end
  end

  // command pins: NOP unless something is issued; NOP needs no timing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= DDC_IDLE;
      tgt_sr_r <= 1'b0;
      wait_cnt_r <= 9'h000;
      ddr_cke <= 1'b1;
      ddr_cs_n <= 1'b1;
      ddr_ras_n <= 1'b1;
      ddr_cas_n <= 1'b1;
      ddr_we_n <= 1'b1;
      ddr_ba <= 2'h0;
      ddr_a <= 13'h0000;
      ddr_odt <= 1'b0;
    end
    else
    begin
      ddr_cs_n <= 1'b0;
      ddr_ras_n <= 1'b1;
      ddr_cas_n <= 1'b1;
      ddr_we_n <= 1'b1;
      ddr_odt <= 1'b0;
      wait_cnt_r <= dec9(wait_cnt_r);
      case (state_r)
        DDC_IDLE:
        begin
          ddr_odt <= ctrl_r[`DDC_CTRL_ODT_BIT];
          if (iss_ref)
          begin
            ddr_ras_n <= 1'b0;
            ddr_cas_n <= 1'b0;
          end
          else if (iss_prea)
          begin
            ddr_ras_n <= 1'b0;
            ddr_we_n <= 1'b0;
            ddr_a <= 13'h0400;
          end
          else if (iss_act)
          begin
            ddr_ras_n <= 1'b0;
            ddr_ba <= cmd_ba_r;
            ddr_a <= cmd_addr_r;
          end
          else if (iss_col)
          begin
            ddr_cas_n <= 1'b0;
            ddr_we_n <= cmd_op_r != DDC_OP_WR;
            ddr_ba <= cmd_ba_r;
            ddr_a <= {2'b00, cmd_ap_r, cmd_addr_r[9:0]};
          end
          else if (iss_odt_off)
          begin
            ddr_odt <= 1'b0;
            tgt_sr_r <= !cmd_valid_r;
            wait_cnt_r <= C_AOFD;
            state_r <= DDC_ODT_OFF;
          end
        end
        DDC_ODT_OFF:
          if (wait_cnt_r <= 9'h001)
          begin
            ddr_ras_n <= 1'b0;
            ddr_cas_n <= 1'b0;
            if (tgt_sr_r)
            begin
              ddr_cke <= 1'b0;
              state_r <= DDC_SREF;
            end
            else
            begin
              ddr_we_n <= 1'b0;
              ddr_ba <= cmd_ba_r;
              ddr_a <= cmd_addr_r;
              wait_cnt_r <= C_MOD;
              state_r <= DDC_MOD_WAIT;
            end
          end
        DDC_MOD_WAIT:
          if (wait_cnt_r <= 9'h001)
            state_r <= DDC_IDLE;
        DDC_SREF:
          // clock keeps running here, so cke rises at once on exit; NOPs then follow for C_XSNR cycles before any command
          if (!ctrl_r[`DDC_CTRL_SR_BIT])
          begin
            ddr_cke <= 1'b1;
            wait_cnt_r <= C_XSNR;
            state_r <= DDC_SR_EXIT;
          end
          else
            ddr_cke <= 1'b0;
        DDC_SR_EXIT:
          if (wait_cnt_r <= 9'h001)
            state_r <= DDC_IDLE;
        default:
          state_r <= DDC_IDLE;
      endcase
    end
  end

  // bank bookkeeping and spacing counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_open_r <= 4'h0;
      for (int i = 0; i < 4; i++)
        bk_cnt_r[i] <= 9'h000;
      rrd_cnt_r <= 9'h000;
      all_cnt_r <= 9'h000;
      col_cnt_r <= 9'h000;
      pre_cnt_r <= 9'h000;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        bk_cnt_r[i] <= dec9(bk_cnt_r[i]);
      rrd_cnt_r <= dec9(rrd_cnt_r);
      all_cnt_r <= dec9(all_cnt_r);
      col_cnt_r <= dec9(col_cnt_r);
      pre_cnt_r <= dec9(pre_cnt_r);
      if (iss_act)
      begin
        bank_open_r[cmd_ba_r] <= 1'b1;
        bk_cnt_r[cmd_ba_r] <= C_RC - 9'h001;
        rrd_cnt_r <= C_RRD - 9'h001;
        pre_cnt_r <= max9(dec9(pre_cnt_r), C_RAS - 9'h001);
      end
      else if (iss_col)
      begin
        col_cnt_r <= C_HALF - 9'h001;
        pre_cnt_r <= max9(dec9(pre_cnt_r), (cmd_op_r == DDC_OP_WR ? C_WR_PRE : C_RD_PRE) - 9'h001);
        if (cmd_ap_r)
        begin
          bank_open_r[cmd_ba_r] <= 1'b0;
          bk_cnt_r[cmd_ba_r] <= max9(dec9(bk_cnt_r[cmd_ba_r]),
            (cmd_op_r == DDC_OP_WR ? C_WR_PRE : C_RD_PRE) + C_RP - 9'h001);
        end
      end
      else if (iss_prea)
      begin
        bank_open_r <= 4'h0;
        all_cnt_r <= C_RP - 9'h001;
      end
      else if (iss_ref)
        all_cnt_r <= C_RFC - 9'h001;
    end
  end

  // refresh debt: a tick in the same cycle as an issue leaves the count unchanged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_tmr_r <= C_REFI - 9'h001;
      owed_r <= 4'h0;
      need_ref_r <= 1'b0;
    end
    else
    begin
      ref_tmr_r <= (ref_tmr_r == 9'h000 || state_r == DDC_SREF) ? C_REFI - 9'h001 : ref_tmr_r - 9'h001;
      if (state_r == DDC_SREF)
        owed_r <= 4'h0;
      else if (ref_tick && !iss_ref && !ref_force)
        owed_r <= owed_r + 4'h1;
      else if (iss_ref && !ref_tick && owed_r != 4'h0)
        owed_r <= owed_r - 4'h1;
      if (state_r == DDC_SR_EXIT)
        need_ref_r <= 1'b1;
      else if (iss_ref)
        need_ref_r <= 1'b0;
    end
  end

  logic act_pin, col_pin, ref_pin, emrs_pin;
  assign act_pin = ddr_cke && !ddr_cs_n && !ddr_ras_n && ddr_cas_n && ddr_we_n;
  assign col_pin = !ddr_cs_n && ddr_ras_n && !ddr_cas_n;
  assign ref_pin = ddr_cke && !ddr_cs_n && !ddr_ras_n && !ddr_cas_n && ddr_we_n;
  assign emrs_pin = !ddr_cs_n && !ddr_ras_n && !ddr_cas_n && !ddr_we_n;

  property p_act_closed;
    @(posedge pclk) disable iff (!presetn)
      act_pin |-> (($past(bank_open_r) & (4'h1 << ddr_ba)) == 4'h0) && bank_open_r[ddr_ba];
  endproperty
  a_act_closed: assert property (p_act_closed) else $error("activate to an open bank");
  property p_col_gap;
    @(posedge pclk) disable iff (!presetn) col_pin |=> !col_pin;
  endproperty
  a_col_gap: assert property (p_col_gap) else $error("column commands too close");
  property p_odt_mod;
    @(posedge pclk) disable iff (!presetn) emrs_pin |-> !ddr_odt ##1 !ddr_odt;
  endproperty
  a_odt_mod: assert property (p_odt_mod) else $error("termination on around mode update");
  property p_sr_cke;
    @(posedge pclk) disable iff (!presetn) state_r == DDC_SREF |-> !ddr_cke && !ddr_odt;
  endproperty
  a_sr_cke: assert property (p_sr_cke) else $error("clock enable high in self-refresh");
  property p_srx_nop;
    @(posedge pclk) disable iff (!presetn)
      state_r == DDC_SR_EXIT |-> ddr_cke && !ddr_odt && ddr_ras_n && ddr_cas_n && ddr_we_n;
  endproperty
  a_srx_nop: assert property (p_srx_nop) else $error("command during self-refresh exit");
  property p_ref_closed;
    @(posedge pclk) disable iff (!presetn) ref_pin |-> $past(bank_open_r) == 4'h0;
  endproperty
  a_ref_closed: assert property (p_ref_closed) else $error("refresh with a bank open");
  property p_owed_max;
    @(posedge pclk) disable iff (!presetn) owed_r <= `DDC_MAX_OWED;
  endproperty
  a_owed_max: assert property (p_owed_max) else $error("too many refreshes postponed");
  property p_ref_gap;
    @(posedge pclk) disable iff (!presetn) ref_pin |=> !ref_pin && !act_pin;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("command inside refresh cycle");
  property p_sre_needs_ref;
    @(posedge pclk) disable iff (!presetn) $rose(state_r == DDC_ODT_OFF) && tgt_sr_r |-> !$past(need_ref_r);
  endproperty
  a_sre_needs_ref: assert property (p_sre_needs_ref) else $error("self-refresh re-entry without refresh");
endmodule // ddc_ctrl
`default_nettype wire

/* ddc_dram_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defs.svh"
module ddc_dram_model #(
  parameter int AL = 0,
  parameter int CL = 4,
  parameter int BL = 4,
  parameter int WR = 1
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ddr_cke,
  input wire logic ddr_cs_n,
  input wire logic ddr_ras_n,
  input wire logic ddr_cas_n,
  input wire logic ddr_we_n,
  input wire logic [1:0] ddr_ba,
  input wire logic [12:0] ddr_a,
  input wire logic ddr_odt,
  output logic [3:0] open_banks,
  output logic [7:0] n_viol,
  output logic [7:0] n_ref,
  output logic in_sr
);
  localparam int RFC = `DDC_CYC(`DDC_T_RFC_NS);
  localparam int XSNR = `DDC_CYC(`DDC_T_XSNR_NS);
  localparam int MOD = `DDC_CYC(`DDC_T_MODMAX_NS);
  localparam int AOFD = `DDC_CYC(`DDC_T_AOFD_NS);
  // no data pins here, so bursts are timed only
  localparam int RD_AP = AL + BL / 2;
  localparam int WR_AP = AL + CL - 1 + BL / 2 + WR;
  logic [3:0] cmd;
  logic [7:0] ap_cnt [4];
  logic need_ref_r;
  int gap_r, ref_r, exit_r, mod_r, odt_r;
  assign cmd = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      open_banks <= 4'h0;
      n_viol <= 8'h00;
      n_ref <= 8'h00;
      in_sr <= 1'b0;
      need_ref_r <= 1'b0;
      gap_r <= 9;
      ref_r <= 999;
      exit_r <= 999;
      mod_r <= 999;
      odt_r <= 0;
      for (int b = 0; b < 4; b++)
        ap_cnt[b] <= 8'h00;
    end
    else
    begin
      gap_r <= gap_r + 1;
      ref_r <= ref_r + 1;
      exit_r <= exit_r + 1;
      mod_r <= mod_r + 1;
      // cycles for which termination has already been seen low
      odt_r <= ddr_odt ? 0 : odt_r + 1;
      for (int b = 0; b < 4; b++)
        if (ap_cnt[b] != 8'h00)
        begin
          ap_cnt[b] <= ap_cnt[b] - 8'h01;
          if (ap_cnt[b] == 8'h01)
            open_banks[b] <= 1'b0;
        end
      if (in_sr)
      begin
        // only the clock enable is heard while refreshing itself
        if (ddr_cke)
        begin
          in_sr <= 1'b0;
          exit_r <= 1;
          need_ref_r <= 1'b1;
        end
      end
      else if (!ddr_cke && cmd == 4'b0001)
      begin
        in_sr <= 1'b1;
        if (ddr_odt || need_ref_r || open_banks != 4'h0)
          n_viol <= n_viol + 8'h01;
      end
      else if (exit_r < XSNR && ((cmd != 4'b0111 && !ddr_cs_n) || ddr_odt || !ddr_cke))
        n_viol <= n_viol + 8'h01;
      else if (!ddr_cs_n)
        case (cmd)
          4'b0011:
          begin
            if (open_banks[ddr_ba] || ref_r < RFC)
              n_viol <= n_viol + 8'h01;
            open_banks[ddr_ba] <= 1'b1;
          end
          4'b0101, 4'b0100:
          begin
            // a column command right after activate is accepted
            if (!open_banks[ddr_ba] || gap_r < 2)
              n_viol <= n_viol + 8'h01;
            gap_r <= 1;
            if (ddr_a[10])
              ap_cnt[ddr_ba] <= ddr_we_n ? 8'(RD_AP) : 8'(WR_AP);
          end
          4'b0010:
            if (ddr_a[10])
              open_banks <= 4'h0;
          4'b0001:
          begin
            if (open_banks != 4'h0 || ref_r < RFC)
              n_viol <= n_viol + 8'h01;
            n_ref <= n_ref + 8'h01;
            ref_r <= 1;
            need_ref_r <= 1'b0;
          end
          4'b0000:
          begin
            if (open_banks != 4'h0 || ddr_odt || odt_r < AOFD)
              n_viol <= n_viol + 8'h01;
            mod_r <= 1;
          end
          default:; // nop leaves every bank as it was
        endcase
      if (!in_sr && mod_r <= MOD && ddr_odt)
        n_viol <= n_viol + 8'h01;
    end
endmodule // ddc_dram_model
`default_nettype wire

/* ddr2_command_bank_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddc_defs.svh"
module ddr2_command_bank_control_test;
  import ddc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_odt, in_sr, bad;
  logic [1:0] ddr_ba, bk;
  logic [12:0] ddr_a, ad;
  logic [3:0] open_banks, exp_open;
  logic [7:0] n_viol, n_ref, cnt;
  logic [31:0] seed = 32'h45f5;
  ddc_op_t op;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #12.5 pclk = ~pclk;
  ddc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_a, .ddr_odt);
  ddc_dram_model #(.AL(0), .CL(4), .BL(4), .WR(`DDC_CYC(`DDC_T_WR_NS))) u_mem (.pclk, .presetn, .ddr_cke,
    .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_a, .ddr_odt, .open_banks, .n_viol, .n_ref, .in_sr);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] cmd_word(input ddc_op_t o, input logic ap, input logic [1:0] b,
    input logic [12:0] a);
    return {11'h000, a, 2'h0, b, ap, o};
  endfunction
  // refused commands leave the mask untouched, which this update gives for free
  function automatic logic [3:0] next_open(input logic [3:0] m, input ddc_op_t o, input logic ap,
    input logic [1:0] b);
    case (o)
      DDC_OP_ACT: return m | (4'h1 << b);
      DDC_OP_PREA: return 4'h0;
      default: return ap ? m & ~(4'h1 << b) : m;
    endcase
  endfunction
  task automatic results();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the request holds until the edge that samples pready high; data is taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic issue(input logic [31:0] w);
    apb(1'b1, `DDC_CMD_OFF, w);
    rdat = 32'h1;
    for (int k = 0; k < 40 && rdat[0] !== 1'b0; k++)
      apb(1'b0, `DDC_STAT_OFF, 32'h0);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DDC_CTRL_OFF, 32'h0);
    check(rdat, `DDC_CTRL_RST);
    check({28'h0, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}, 32'h7);
    apb(1'b1, 12'h0fc, 32'hffff_ffff);
    check({31'h0, rerr}, 32'h1);
    exp_open = 4'h0;
    for (int i = 0; i < 48; i++)
    begin
      seed = xs(seed);
      op = (i % 12 == 11) ? DDC_OP_PREA : ddc_op_t'({1'b0, (seed[1:0] == 2'h3) ? 2'h0 : seed[1:0]});
      bk = seed[5:4];
      ad = (op == DDC_OP_ACT) ? seed[20:8] : {3'h0, (i == 5) ? 10'h3ff : seed[17:8]};
      bad = (op == DDC_OP_ACT) ? exp_open[bk] : (op != DDC_OP_PREA && !exp_open[bk]);
      issue(cmd_word(op, seed[3], bk, ad));
      exp_open = next_open(exp_open, op, seed[3], bk);
      repeat (12) @(posedge pclk);
      check({28'h0, open_banks}, {28'h0, exp_open});
      apb(1'b0, `DDC_STAT_OFF, 32'h0);
      check({28'h0, rdat[7:4]}, {28'h0, exp_open});
      check({31'h0, rdat[16]}, {31'h0, bad});
      if (bad)
        apb(1'b1, `DDC_STAT_OFF, 32'h1 << `DDC_STAT_ERR_BIT);
    end
    issue(cmd_word(DDC_OP_PREA, 1'b0, 2'h0, 13'h0));
    apb(1'b1, `DDC_CTRL_OFF, 32'h4);
    issue(cmd_word(DDC_OP_EMRS, 1'b0, 2'h1, 13'h0044));
    repeat (8) @(posedge pclk);
    check({31'h0, ddr_odt}, 32'h1);
    issue(cmd_word(DDC_OP_ACT, 1'b0, 2'h2, 13'h1abc));
    apb(1'b1, `DDC_CTRL_OFF, 32'h2);
    cnt = n_ref;
    // an open bank defers refresh until eight are owed, then precharge-all and the whole debt follow
    repeat (2700) @(posedge pclk);
    check({31'h0, (n_ref - cnt) >= 8'h08}, 32'h1);
    check({28'h0, open_banks}, 32'h0);
    apb(1'b1, `DDC_CTRL_OFF, 32'h3);
    repeat (40) @(posedge pclk);
    check({30'h0, in_sr, ddr_cke}, 32'h2);
    apb(1'b0, `DDC_STAT_OFF, 32'h0);
    check({31'h0, rdat[1]}, 32'h1);
    apb(1'b1, `DDC_CTRL_OFF, 32'h2);
    apb(1'b1, `DDC_CTRL_OFF, 32'h3);
    cnt = n_ref;
    repeat (40) @(posedge pclk);
    check({31'h0, in_sr}, 32'h1);
    check({31'h0, n_ref != cnt}, 32'h1);
    apb(1'b1, `DDC_CTRL_OFF, 32'h0);
    repeat (20) @(posedge pclk);
    check({30'h0, in_sr, ddr_cke}, 32'h1);
    check({24'h0, n_viol}, 32'h0);
    results();
  end
endmodule // ddr2_command_bank_control_test
`default_nettype wire
